/* src/hpm_pkg.sv */
// Constants and types for the host port strobe/address pin mux
package hpm_pkg;
   localparam int NUM_PINS = 3;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   // Register offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_POL = 4'h1;
   localparam logic [3:0] OFS_GPIO_DIR = 4'h2;
   localparam logic [3:0] OFS_GPIO_OUT = 4'h3;
   localparam logic [3:0] OFS_GPIO_IN = 4'h4;
   localparam logic [3:0] OFS_HOST_STAT = 4'h5;
   // Control fields
   localparam int CTRL_HOST_EN_BIT = 0;
   localparam int CTRL_MUXED_BIT = 1;
   localparam int CTRL_DOUBLE_BIT = 2;
   // Polarity fields: 1 = active high
   localparam int POL_RD_BIT = 0;
   localparam int POL_WR_BIT = 1;
   localparam int POL_DS_BIT = 2;
   // Reset values
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [2:0] POL_RESET = 3'h0;
   localparam logic [1:0] DIR_RESET = 2'h0;
   localparam logic [2:0] OUT_RESET = 3'h0;
   // Status field positions
   localparam int ST_ADDR2_BIT = 0;
   localparam int ST_ADDR9_BIT = 1;
   localparam int ST_RW_BIT = 2;
   localparam int ST_RD_BIT = 3;
   localparam int ST_WR_BIT = 4;
   localparam int ST_DS_BIT = 5;
   // Per-line direction encoding
   typedef enum logic [1:0] {
      DIR_DISC = 2'h0,
      DIR_IN = 2'h1,
      DIR_OUT = 2'h2
   } hpm_dir_type;
endpackage : hpm_pkg

/* src/hpm_sync.sv */
// Two-flop synchroniser for one pin input
`timescale 1ns/1ns
module hpm_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic d,
   output logic q
);
   typedef struct packed {
      logic meta;
      logic sync;
   } hpm_sync_state_type;
   hpm_sync_state_type s_r;
   hpm_sync_state_type s_nxt;
   always_comb begin
      s_nxt.meta = d;
      s_nxt.sync = s_r.meta;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign q = s_r.sync;
endmodule : hpm_sync

/* src/hpm_pin_mux.sv */
// Pin mux for three shared host port pins
// What this block does
// - Host, non-multiplexed bus: first pin is host address bit two.
// - Host, multiplexed bus: first pin is host address bit nine.
// - General-purpose mode: pins are port lines ten, eleven, twelve.
// - Each port line separately input, output or disconnected.
// - After reset all three pins are general-purpose disconnected.
// - Single strobe host mode: second pin is read/write direction input.
// - Double strobe host mode: second pin is read strobe input.
// - Single strobe host mode: third pin is data strobe input.
// - Double strobe host mode: third pin is write strobe input.
// - Strobe polarity programmable, active-low after reset.
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ns
module hpm_pin_mux (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [2:0] pin_in,
   output logic [2:0] pin_out,
   output logic [2:0] pin_oe,
   output logic host_addr_bit_two,
   output logic host_addr_bit_nine,
   output logic host_rw_direction,
   output logic host_read_strobe,
   output logic host_write_strobe,
   output logic host_single_strobe,
   output logic host_function_select
);
   typedef struct packed {
      logic [2:0] ctrl;
      logic [2:0] pol;
      logic [5:0] dir;
      logic [2:0] gout;
      logic [7:0] rdata;
      logic a2;
      logic a9;
      logic rw;
      logic rd;
      logic wr;
      logic ds;
   } hpm_state_type;

   hpm_state_type st_r;
   hpm_state_type st_nxt;
   logic [2:0] pin_sync;
   logic host_en;
   logic muxed;
   logic dbl;
   logic [5:0] host_stat;
   logic [2:0] gpio_in;

   genvar gi;
   generate
      for (gi = 0; gi < hpm_pkg::NUM_PINS; gi++) begin : g_sync
         hpm_sync u_sync (
            .clk(clk),
            .rst(rst),
            .d(pin_in[gi]),
            .q(pin_sync[gi])
         );
      end
   endgenerate

   assign host_en = st_r.ctrl[hpm_pkg::CTRL_HOST_EN_BIT];
   assign muxed = st_r.ctrl[hpm_pkg::CTRL_MUXED_BIT];
   assign dbl = st_r.ctrl[hpm_pkg::CTRL_DOUBLE_BIT];

   always_comb begin
      gpio_in = 3'h0;
      for (int i = 0; i < hpm_pkg::NUM_PINS; i++) begin
         if (!host_en && st_r.dir[2*i +: 2] == hpm_pkg::DIR_IN) begin
            gpio_in[i] = pin_sync[i];
         end
      end
   end

   always_comb begin
      host_stat = 6'h0;
      host_stat[hpm_pkg::ST_ADDR2_BIT] = st_r.a2;
      host_stat[hpm_pkg::ST_ADDR9_BIT] = st_r.a9;
      host_stat[hpm_pkg::ST_RW_BIT] = st_r.rw;
      host_stat[hpm_pkg::ST_RD_BIT] = st_r.rd;
      host_stat[hpm_pkg::ST_WR_BIT] = st_r.wr;
      host_stat[hpm_pkg::ST_DS_BIT] = st_r.ds;
   end

   always_comb begin
      st_nxt = st_r;
      // Register writes
      if (reg_wr) begin
         unique case (reg_addr)
            hpm_pkg::OFS_CTRL: st_nxt.ctrl = reg_wdata[2:0];
            hpm_pkg::OFS_POL: st_nxt.pol = reg_wdata[2:0];
            hpm_pkg::OFS_GPIO_DIR: st_nxt.dir = reg_wdata[5:0];
            hpm_pkg::OFS_GPIO_OUT: st_nxt.gout = reg_wdata[2:0];
            default: ;
         endcase
      end
      // Read data valid only the cycle after the strobe
      st_nxt.rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            hpm_pkg::OFS_CTRL: st_nxt.rdata = {5'h00, st_r.ctrl};
            hpm_pkg::OFS_POL: st_nxt.rdata = {5'h00, st_r.pol};
            hpm_pkg::OFS_GPIO_DIR: st_nxt.rdata = {2'h0, st_r.dir};
            hpm_pkg::OFS_GPIO_OUT: st_nxt.rdata = {5'h00, st_r.gout};
            hpm_pkg::OFS_GPIO_IN: st_nxt.rdata = {5'h00, gpio_in};
            hpm_pkg::OFS_HOST_STAT: st_nxt.rdata = {2'h0, host_stat};
            default: st_nxt.rdata = 8'h00;
         endcase
      end
      st_nxt.a2 = 1'b0;
      st_nxt.a9 = 1'b0;
      st_nxt.rw = 1'b0;
      st_nxt.rd = 1'b0;
      st_nxt.wr = 1'b0;
      st_nxt.ds = 1'b0;
      if (host_en) begin
         if (!muxed) begin
            st_nxt.a2 = pin_sync[0];
         end else begin
            st_nxt.a9 = pin_sync[0];
         end
         if (dbl) begin
            st_nxt.rd = pin_sync[1] ~^ st_r.pol[hpm_pkg::POL_RD_BIT];
            st_nxt.wr = pin_sync[2] ~^ st_r.pol[hpm_pkg::POL_WR_BIT];
         end else begin
            st_nxt.rw = pin_sync[1];
            st_nxt.ds = pin_sync[2] ~^ st_r.pol[hpm_pkg::POL_DS_BIT];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r.ctrl <= hpm_pkg::CTRL_RESET;
         st_r.pol <= hpm_pkg::POL_RESET;
         st_r.dir <= {hpm_pkg::DIR_RESET, hpm_pkg::DIR_RESET,
            hpm_pkg::DIR_RESET};
         st_r.gout <= hpm_pkg::OUT_RESET;
         st_r.rdata <= 8'h00;
         st_r.a2 <= 1'b0;
         st_r.a9 <= 1'b0;
         st_r.rw <= 1'b0;
         st_r.rd <= 1'b0;
         st_r.wr <= 1'b0;
         st_r.ds <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   always_comb begin
      pin_out = 3'h0;
      pin_oe = 3'h0;
      for (int i = 0; i < hpm_pkg::NUM_PINS; i++) begin
         if (!host_en && st_r.dir[2*i +: 2] == hpm_pkg::DIR_OUT) begin
            pin_out[i] = st_r.gout[i];
            pin_oe[i] = 1'b1;
         end
      end
   end

   assign reg_rdata = st_r.rdata;
   assign host_addr_bit_two = st_r.a2;
   assign host_addr_bit_nine = st_r.a9;
   assign host_rw_direction = st_r.rw;
   assign host_read_strobe = st_r.rd;
   assign host_write_strobe = st_r.wr;
   assign host_single_strobe = st_r.ds;
   assign host_function_select = host_en;

   // a_reset_disc: after reset no pin is driven
   a_reset_disc: assert property (@(posedge clk)
      $past(rst) && !rst |-> pin_oe == 3'h0 && !host_function_select)
      else $error("pins driven after reset");
   a_gpio_no_host: assert property (@(posedge clk) disable iff (rst)
      !host_en |-> ##1 !(host_read_strobe || host_write_strobe
      || host_single_strobe) || $past(host_en) == 1'b1)
      else $error("host strobe seen in gpio mode");
   a_out_drive: assert property (@(posedge clk) disable iff (rst)
      (!host_en && st_r.dir[1:0] == hpm_pkg::DIR_OUT) |->
      pin_oe[0] && pin_out[0] == st_r.gout[0])
      else $error("port line ten not driven");
   a_host_no_oe: assert property (@(posedge clk) disable iff (rst)
      host_en |-> pin_oe == 3'h0)
      else $error("pin driven in host mode");
   a_addr_two: assert property (@(posedge clk) disable iff (rst)
      (host_en && !muxed) ##1 (host_en && !muxed) |->
      host_addr_bit_two == $past(pin_sync[0]))
      else $error("address bit two wrong");
   a_addr_nine: assert property (@(posedge clk) disable iff (rst)
      (host_en && muxed) ##1 (host_en && muxed) |->
      host_addr_bit_nine == $past(pin_sync[0]) && !host_addr_bit_two)
      else $error("address bit nine wrong");
   a_rw_dir: assert property (@(posedge clk) disable iff (rst)
      (host_en && !dbl) ##1 (host_en && !dbl) |->
      host_rw_direction == $past(pin_sync[1]))
      else $error("read/write direction wrong");
   a_read_strobe: assert property (@(posedge clk) disable iff (rst)
      (host_en && dbl && !st_r.pol[hpm_pkg::POL_RD_BIT] && !pin_sync[1]) |=>
      host_read_strobe || !host_en)
      else $error("active-low read strobe missed");
   a_data_strobe: assert property (@(posedge clk) disable iff (rst)
      (host_en && !dbl && st_r.pol[hpm_pkg::POL_DS_BIT] && pin_sync[2]) |=>
      host_single_strobe || !host_en)
      else $error("data strobe missed");
   a_write_strobe: assert property (@(posedge clk) disable iff (rst)
      (host_en && dbl && !st_r.pol[hpm_pkg::POL_WR_BIT] && !pin_sync[2]) |=>
      host_write_strobe || !host_en)
      else $error("active-low write strobe missed");
   a_pol_default: assert property (@(posedge clk)
      $past(rst) && !rst |-> st_r.pol == hpm_pkg::POL_RESET)
      else $error("polarity not active-low after reset");
   a_sync_delay: assert property (@(posedge clk) disable iff (rst)
      $rose(pin_in[2]) ##1 $stable(pin_in[2]) |=> pin_sync[2])
      else $error("synchroniser latency wrong");

   // Port line drivers and inputs per direction field
   a_out_eleven: assert property (@(posedge clk) disable iff (rst)
      (!host_en && st_r.dir[3:2] == hpm_pkg::DIR_OUT) |->
      pin_oe[1] && pin_out[1] == st_r.gout[1])
      else $error("port line eleven not driven");
   a_out_twelve: assert property (@(posedge clk) disable iff (rst)
      (!host_en && st_r.dir[5:4] == hpm_pkg::DIR_OUT) |->
      pin_oe[2] && pin_out[2] == st_r.gout[2])
      else $error("port line twelve not driven");
   a_disc_ten: assert property (@(posedge clk) disable iff (rst)
      st_r.dir[1:0] != hpm_pkg::DIR_OUT |->
      !pin_oe[0] && !pin_out[0])
      else $error("port line ten driven unasked");
   a_disc_eleven: assert property (@(posedge clk) disable iff (rst)
      st_r.dir[3:2] != hpm_pkg::DIR_OUT |->
      !pin_oe[1] && !pin_out[1])
      else $error("port line eleven driven unasked");
   a_disc_twelve: assert property (@(posedge clk) disable iff (rst)
      st_r.dir[5:4] != hpm_pkg::DIR_OUT |->
      !pin_oe[2] && !pin_out[2])
      else $error("port line twelve driven unasked");
   a_in_none: assert property (@(posedge clk) disable iff (rst)
      (host_en || st_r.dir[1:0] != hpm_pkg::DIR_IN) |->
      !gpio_in[0])
      else $error("port line ten read while not input");
   a_in_ten: assert property (@(posedge clk) disable iff (rst)
      (!host_en && st_r.dir[1:0] == hpm_pkg::DIR_IN) |->
      gpio_in[0] == pin_sync[0])
      else $error("port line ten input lost");
   a_in_read: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == hpm_pkg::OFS_GPIO_IN) |=>
      reg_rdata == {5'h00, $past(gpio_in)})
      else $error("port line inputs misread");

   // Function select and address roles
   a_gpio_quiet: assert property (@(posedge clk) disable iff (rst)
      !host_en |=>
      !host_addr_bit_two && !host_addr_bit_nine && !host_rw_direction)
      else $error("host address seen in gpio mode");
   a_ctrl_write: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && reg_addr == hpm_pkg::OFS_CTRL) |=>
      st_r.ctrl == $past(reg_wdata[2:0]))
      else $error("function select not taken");
   a_two_muxed: assert property (@(posedge clk) disable iff (rst)
      (host_en && muxed) |=> !host_addr_bit_two)
      else $error("address bit two live in multiplexed mode");
   a_nine_plain: assert property (@(posedge clk) disable iff (rst)
      (host_en && !muxed) |=> !host_addr_bit_nine)
      else $error("address bit nine live in plain mode");

   // Strobe roles by bus style
   a_rw_double: assert property (@(posedge clk) disable iff (rst)
      dbl |=> !host_rw_direction)
      else $error("direction input live in double strobe mode");
   a_rd_single: assert property (@(posedge clk) disable iff (rst)
      !dbl |=> !host_read_strobe)
      else $error("read strobe live in single strobe mode");
   a_wr_single: assert property (@(posedge clk) disable iff (rst)
      !dbl |=> !host_write_strobe)
      else $error("write strobe live in single strobe mode");
   a_ds_double: assert property (@(posedge clk) disable iff (rst)
      dbl |=> !host_single_strobe)
      else $error("data strobe live in double strobe mode");
   a_read_high: assert property (@(posedge clk) disable iff (rst)
      (host_en && dbl && st_r.pol[hpm_pkg::POL_RD_BIT] && pin_sync[1]) |=>
      host_read_strobe)
      else $error("active-high read strobe missed");
   a_read_idle: assert property (@(posedge clk) disable iff (rst)
      (host_en && dbl && pin_sync[1] != st_r.pol[hpm_pkg::POL_RD_BIT]) |=>
      !host_read_strobe)
      else $error("inactive read strobe seen");
   a_write_high: assert property (@(posedge clk) disable iff (rst)
      (host_en && dbl && st_r.pol[hpm_pkg::POL_WR_BIT] && pin_sync[2]) |=>
      host_write_strobe)
      else $error("active-high write strobe missed");
   a_write_idle: assert property (@(posedge clk) disable iff (rst)
      (host_en && dbl && pin_sync[2] != st_r.pol[hpm_pkg::POL_WR_BIT]) |=>
      !host_write_strobe)
      else $error("inactive write strobe seen");
   a_ds_low: assert property (@(posedge clk) disable iff (rst)
      (host_en && !dbl && !st_r.pol[hpm_pkg::POL_DS_BIT] && !pin_sync[2]) |=>
      host_single_strobe)
      else $error("active-low data strobe missed");
   a_ds_idle: assert property (@(posedge clk) disable iff (rst)
      (host_en && !dbl && pin_sync[2] != st_r.pol[hpm_pkg::POL_DS_BIT]) |=>
      !host_single_strobe)
      else $error("inactive data strobe seen");

   // State after reset release, and polarity register write
   a_dir_reset: assert property (@(posedge clk)
      $past(rst) && !rst |->
      st_r.dir == {hpm_pkg::DIR_RESET, hpm_pkg::DIR_RESET,
      hpm_pkg::DIR_RESET})
      else $error("port directions not disconnected after reset");
   a_host_reset: assert property (@(posedge clk)
      $past(rst) && !rst |-> !host_addr_bit_two && !host_addr_bit_nine
      && !host_rw_direction && !host_read_strobe
      && !host_write_strobe && !host_single_strobe)
      else $error("host outputs live after reset");
   a_pol_write: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && reg_addr == hpm_pkg::OFS_POL) |=>
      st_r.pol == $past(reg_wdata[2:0]))
      else $error("strobe polarity not taken");

   // Synchroniser latency: falling edge on the third pin, rising edge on the other pins
   a_sync_fall: assert property (@(posedge clk) disable iff (rst)
      $fell(pin_in[2]) ##1 $stable(pin_in[2]) |=> !pin_sync[2])
      else $error("synchroniser fall latency wrong");
   a_sync_mid: assert property (@(posedge clk) disable iff (rst)
      $rose(pin_in[1]) ##1 $stable(pin_in[1]) |=> pin_sync[1])
      else $error("second pin synchroniser latency wrong");
   a_sync_first: assert property (@(posedge clk) disable iff (rst)
      $rose(pin_in[0]) ##1 $stable(pin_in[0]) |=> pin_sync[0])
      else $error("first pin synchroniser latency wrong");

   c_host_single: cover property (@(posedge clk) host_single_strobe);
   c_host_read: cover property (@(posedge clk) host_read_strobe);
   c_host_write: cover property (@(posedge clk) host_write_strobe);
   c_addr_nine: cover property (@(posedge clk) host_addr_bit_nine);
   c_gpio_out: cover property (@(posedge clk) pin_oe == 3'h7);
endmodule : hpm_pin_mux

/* verification/hpm_host_model.sv */
// Host bus model driving the three shared pins
`timescale 1ns/1ns
module hpm_host_model (
   input wire logic clk,
   input wire logic go,
   input wire logic dbl,
   input wire logic wr,
   input wire logic addr,
   input wire logic [2:0] pol,
   input wire logic [2:0] idle,
   output logic [2:0] pins
);
   logic [2:0] act_r = 3'h0;
   logic [2:0] cnt_r = 3'h0;
   always_ff @(posedge clk) begin
      if (go) begin
         cnt_r <= 3'h6;
         act_r <= dbl ? {wr ~^ pol[1], ~wr ~^ pol[0], addr}
                      : {pol[2], ~wr, addr};
      end else if (cnt_r != 3'h0) begin
         cnt_r <= cnt_r - 3'h1;
      end
   end
   // Idle level outside an access
   assign pins = (cnt_r != 3'h0) ? act_r : idle;
endmodule : hpm_host_model

/* verification/host_port_strobe_address_pin_mux_tb.sv */
// Bench for the host port pin mux
`timescale 1ns/1ns
module host_port_strobe_address_pin_mux_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [2:0] pin_out, pin_oe, pw, drv, pol = 3'h0, idle = 3'h0;
   logic go = 1'b0, dbl = 1'b0, hw = 1'b0, ha = 1'b0;
   logic host_addr_bit_two, host_addr_bit_nine, host_rw_direction;
   logic host_read_strobe, host_write_strobe, host_single_strobe;
   logic host_function_select;
   logic [7:0] hv;
   int fails = 0;
   int n_checks = 0;
   always #50 clk = ~clk;
   assign pw = (pin_oe & pin_out) | (~pin_oe & drv);
   assign hv = {2'h0, host_single_strobe, host_write_strobe,
      host_read_strobe, host_rw_direction, host_addr_bit_nine,
      host_addr_bit_two};
   hpm_pin_mux uut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .pin_in(pw), .pin_out, .pin_oe, .host_addr_bit_two,
      .host_addr_bit_nine, .host_rw_direction, .host_read_strobe,
      .host_write_strobe, .host_single_strobe, .host_function_select);
   hpm_host_model host (.clk, .go, .dbl, .wr(hw), .addr(ha), .pol, .idle,
      .pins(drv));
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic wreg(logic [3:0] a, logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wreg
   task automatic rreg(logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rreg
   function automatic logic [7:0] eh(logic [2:0] c, p, n);
      return {2'h0, c[0] & ~c[2] & (n[2] ~^ p[2]),
         c[0] & c[2] & (n[2] ~^ p[1]), c[0] & c[2] & (n[1] ~^ p[0]),
         c[0] & ~c[2] & n[1], c[0] & c[1] & n[0], c[0] & ~c[1] & n[0]};
   endfunction : eh
   function automatic logic [7:0] eg(logic [5:0] d, logic [2:0] n, int o);
      eg = 8'h00;
      for (int i = 0; i < 3; i++) begin
         eg[i] = (d[2*i+:2] == 2'(o)) & n[i];
      end
   endfunction : eg
   task automatic summarize();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      summarize();
   end
   initial begin
      logic [7:0] d;
      logic [5:0] dr;
      logic [2:0] c, p, o, old;
      void'($urandom(32'h410D93A6));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 7; a++) begin
         rreg(a == 6 ? 4'hF : 4'(a), d);
         chk("reset reg", 8'h00, d);
      end
      chk("reset oe", 8'h00, {5'h0, pin_oe});
      wreg(hpm_pkg::OFS_HOST_STAT, 8'hFF);
      for (int k = 0; k < 8; k++) begin
         // Corner cases: all lines output, then all input
         dr = k == 0 ? 6'h2A : k == 1 ? 6'h15 : 6'($urandom);
         o = 3'($urandom);
         @(posedge clk);
         idle <= 3'($urandom);
         wreg(hpm_pkg::OFS_GPIO_DIR, {2'h0, dr});
         wreg(hpm_pkg::OFS_GPIO_OUT, {5'h0, o});
         repeat (3) @(posedge clk);
         #1 chk("pin_oe", eg(dr, 3'h7, 2), {5'h0, pin_oe});
         chk("pin_out", eg(dr, o, 2), {5'h0, pin_oe & pin_out});
         rreg(hpm_pkg::OFS_GPIO_IN, d);
         chk("gpio_in", eg(dr, idle, 1), d);
         rreg(hpm_pkg::OFS_HOST_STAT, d);
         chk("stat gpio", 8'h00, d);
      end
      for (int m = 0; m < 8; m++) begin
         c = {m[1], m[0], 1'b1};
         p = 3'($urandom);
         wreg(hpm_pkg::OFS_POL, {5'h0, p});
         wreg(hpm_pkg::OFS_CTRL, {5'h0, c});
         pol <= p;
         dbl <= c[2];
         hw <= m[2];
         ha <= 1'($urandom);
         o = 3'($urandom);
         idle <= c[2] ? {~p[1], ~p[0], o[0]} : {~p[2], o[1:0]};
         repeat (4) @(posedge clk);
         #1 old = pw;
         chk("host idle", eh(c, p, pw), hv);
         chk("host oe", 8'h00, {4'h0, pin_oe, ~host_function_select});
         @(posedge clk);
         go <= 1'b1;
         @(posedge clk);
         go <= 1'b0;
         repeat (2) @(posedge clk);
         #1 chk("sync lag", eh(c, p, old), hv);
         @(posedge clk);
         #1 chk("host act", eh(c, p, pw), hv);
         rreg(hpm_pkg::OFS_HOST_STAT, d);
         chk("host stat", eh(c, p, pw), d);
         repeat (6) @(posedge clk);
      end
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rreg(hpm_pkg::OFS_CTRL, d);
      chk("rerst ctrl", 8'h00, d);
      rreg(hpm_pkg::OFS_POL, d);
      chk("rerst pol", 8'h00, d);
      chk("rerst pins", 8'h00, {4'h0, pin_oe, host_function_select});
      chk("rerst host", 8'h00, hv);
      summarize();
   end
endmodule : host_port_strobe_address_pin_mux_tb
